//--- pkg/gpib_ops_defs.svh
// Constants for the instrument-bus poll, reset, resume and send block
`ifndef GPIB_OPS_DEFS_SVH
`define GPIB_OPS_DEFS_SVH
`define K_CMD 4'h0
`define K_UNT 4'h1
`define K_UNL 4'h2
`define K_MTA 4'h3
`define K_MLA 4'h4
`define K_TALK 4'h5
`define K_LISTEN 4'h6
`define K_DATA 4'h7
`define K_DATA_EOI 4'h8
`define UNT_BYTE 8'h5F
`define UNL_BYTE 8'h3F
`define TAG_BASE 8'h40
`define LAG_BASE 8'h20
`define ADDR_MAX 8'h1E
`define SEQ_MAX 9'h0FF
`define RSV_BIT 6
`define TRIGGER_DISARMED_DEFAULT 1'b0
`define INCREMENTING_BUFFER_DEFAULT 1'b1
`define CONFIG_DEFAULT 8'h00
`define CLK_MHZ 250
`define IFC_MIN_US 500
`define IFC_CYCLES (`IFC_MIN_US * `CLK_MHZ)
`define SETTLE_NS 500
`define SETTLE_CYC ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`endif

//--- pkg/gpib_ops_pkg.sv
// Types for the instrument-bus poll, reset, resume and send block
`default_nettype none
package gpib_ops_pkg;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_WAIT_RFD = 3'h1, HS_SETTLE = 3'h3, HS_WAIT_DAC = 3'h2, HS_RELEASE = 3'h6
  } hs_state_t;
  typedef enum logic [1:0] {MS_RUN = 2'h0, MS_FLUSH = 2'h1, MS_IFC = 2'h3} main_state_t;
endpackage : gpib_ops_pkg
`default_nettype wire

//--- verilog/seq_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module seq_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] count_r;
  logic push, pop;
  assign in_ready = count_r != (AW+1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : seq_fifo
`default_nettype wire

//--- verilog/bus_source_hs.sv
// Source side of the three-wire byte handshake
`timescale 1ns/1ps
`default_nettype none
`include "gpib_ops_defs.svh"
module bus_source_hs #(
  parameter int SETTLE_CYCLES = `SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic abort,
  // Byte request
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_eoi,
  // Bus lines, asserted level is 1
  output logic [7:0] dio_out,
  output logic dio_oe,
  output logic dav_out,
  output logic eoi_out,
  input wire logic nrfd_in,
  input wire logic ndac_in
);
  gpib_ops_pkg::hs_state_t state_r;
  logic [7:0] settle_r;
  assign tx_ready = state_r == gpib_ops_pkg::HS_IDLE;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= gpib_ops_pkg::HS_IDLE;
      settle_r <= 8'h00;
      dio_out <= 8'h00;
      dio_oe <= 1'b0;
      dav_out <= 1'b0;
      eoi_out <= 1'b0;
    end else if (abort) begin
      state_r <= gpib_ops_pkg::HS_IDLE;
      dio_oe <= 1'b0;
      dav_out <= 1'b0;
      eoi_out <= 1'b0;
    end else begin
      case (state_r)
        gpib_ops_pkg::HS_IDLE: if (tx_valid) begin
          dio_out <= tx_byte;
          eoi_out <= tx_eoi;
          dio_oe <= 1'b1;
          state_r <= gpib_ops_pkg::HS_WAIT_RFD;
        end
        gpib_ops_pkg::HS_WAIT_RFD: if (!nrfd_in) begin
          settle_r <= 8'(SETTLE_CYCLES - 1);
          state_r <= gpib_ops_pkg::HS_SETTLE;
        end
        gpib_ops_pkg::HS_SETTLE: begin
          // Lines and ATN settle before DAV is trusted
          if (settle_r == 8'h00) begin
            dav_out <= 1'b1;
            state_r <= gpib_ops_pkg::HS_WAIT_DAC;
          end else begin
            settle_r <= settle_r - 8'h01;
          end
        end
        gpib_ops_pkg::HS_WAIT_DAC: if (!ndac_in) begin
          dav_out <= 1'b0;
          state_r <= gpib_ops_pkg::HS_RELEASE;
        end
        gpib_ops_pkg::HS_RELEASE: if (ndac_in) begin
          dio_oe <= 1'b0;
          eoi_out <= 1'b0;
          state_r <= gpib_ops_pkg::HS_IDLE;
        end
        default: state_r <= gpib_ops_pkg::HS_IDLE;
      endcase
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_dav_after_rfd;
    $rose(dav_out) |-> !$past(nrfd_in, SETTLE_CYCLES + 1) && dio_oe;
  endproperty
  a_dav_after_rfd: assert property (p_dav_after_rfd) else $error("DAV without ready");
  property p_dav_release;
    $fell(dav_out) && !$past(abort) |-> !$past(ndac_in) && dio_oe;
  endproperty
  a_dav_release: assert property (p_dav_release) else $error("DAV dropped early");
endmodule : bus_source_hs
`default_nettype wire

//--- verilog/gpib_poll_reset_send_ops.sv
// Poll response, warm reset, attention release and send sequencer
`timescale 1ns/1ps
`default_nettype none
`include "gpib_ops_defs.svh"
module gpib_poll_reset_send_ops #(
  parameter int IFC_CYCLES = `IFC_CYCLES,
  parameter int SETTLE_CYCLES = `SETTLE_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Roles and own address
  input wire logic controller_active,
  input wire logic system_controller,
  input wire logic [4:0] my_addr,
  // Serial poll response
  input wire logic set_poll_response_op,
  input wire logic [7:0] poll_byte_in,
  input wire logic poll_served,
  output logic [7:0] poll_resp_out,
  // Operating mode and warm reset
  input wire logic warm_reset_op,
  input wire logic mode_we,
  input wire logic [3:0] mode_in,
  input wire logic config_we,
  input wire logic [7:0] config_in,
  output logic running_out,
  output logic trigger_armed_out,
  output logic buf_increment_out,
  output logic dma_single_out,
  output logic [7:0] config_out,
  // Attention release
  input wire logic release_attention_op,
  // Send sequence entries
  input wire logic send_sequence_op,
  output logic seq_ready,
  input wire logic [3:0] seq_kind,
  input wire logic [7:0] seq_arg,
  input wire logic seq_last,
  output logic busy_out,
  // Error flags
  output logic err_not_cic_out,
  output logic err_arg_out,
  output logic err_len_out,
  // Bus lines, asserted level is 1
  output logic atn_out,
  output logic ifc_out,
  output logic srq_out,
  output logic [7:0] dio_out,
  output logic dio_oe,
  output logic dav_out,
  output logic eoi_out,
  input wire logic nrfd_in,
  input wire logic ndac_in
);
  // ==========================================================
  // Declarations
  gpib_ops_pkg::main_state_t state_r;
  logic [31:0] ifc_cnt_r;
  logic [8:0] seq_cnt_r;
  logic seq_over;
  logic seq_take;
  logic fifo_in_valid, fifo_in_ready;
  logic fifo_valid, fifo_out_ready;
  logic [11:0] fifo_data;
  logic [3:0] head_kind;
  logic [7:0] head_arg;
  logic head_cmd, head_bad, not_cic_hit, head_drop;
  logic [7:0] tx_byte;
  logic tx_eoi, tx_valid, tx_ready;
  logic run, pop_ok, send_go, flush;
  logic resume_ok, resume_bad;

  assign run = state_r == gpib_ops_pkg::MS_RUN;
  assign flush = state_r == gpib_ops_pkg::MS_FLUSH;

  // ==========================================================
  // Serial poll response
  // load byte in peripheral role
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      poll_resp_out <= 8'h00;
    end else if (set_poll_response_op && !controller_active) begin
      poll_resp_out <= poll_byte_in;
    end else if (poll_served) begin
      // poll served clears request, a fresh load wins
      poll_resp_out[`RSV_BIT] <= 1'b0;
    end
  end

  assign srq_out = poll_resp_out[`RSV_BIT] && !controller_active;

  // ==========================================================
  // Operating mode
  // defaults on warm reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      running_out <= 1'b0;
      trigger_armed_out <= `TRIGGER_DISARMED_DEFAULT;
      buf_increment_out <= `INCREMENTING_BUFFER_DEFAULT;
      dma_single_out <= 1'b1;
      config_out <= `CONFIG_DEFAULT;
    end else if (warm_reset_op) begin
      running_out <= 1'b0;
      trigger_armed_out <= `TRIGGER_DISARMED_DEFAULT;
      buf_increment_out <= `INCREMENTING_BUFFER_DEFAULT;
      dma_single_out <= 1'b1;
      config_out <= `CONFIG_DEFAULT;
    end else begin
      if (mode_we) begin
        running_out <= mode_in[0];
        trigger_armed_out <= mode_in[1];
        buf_increment_out <= !mode_in[2];
        dma_single_out <= !mode_in[3];
      end
      if (config_we) config_out <= config_in;
    end
  end

  // ==========================================================
  // Sequencer state and interface clear timer
  // Warm reset spends one cycle flushing the queue and aborting the byte in flight
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= gpib_ops_pkg::MS_RUN;
      ifc_cnt_r <= 32'h0;
      ifc_out <= 1'b0;
    end else if (warm_reset_op) begin
      state_r <= gpib_ops_pkg::MS_FLUSH;
      ifc_out <= 1'b0;
    end else begin
      case (state_r)
        gpib_ops_pkg::MS_RUN: state_r <= gpib_ops_pkg::MS_RUN;
        gpib_ops_pkg::MS_FLUSH: begin
          if (system_controller) begin
            ifc_out <= 1'b1;
            ifc_cnt_r <= 32'(IFC_CYCLES - 1);
            state_r <= gpib_ops_pkg::MS_IFC;
          end else begin
            state_r <= gpib_ops_pkg::MS_RUN;
          end
        end
        gpib_ops_pkg::MS_IFC: begin
          if (ifc_cnt_r == 32'h0) begin
            ifc_out <= 1'b0;
            state_r <= gpib_ops_pkg::MS_RUN;
          end else begin
            ifc_cnt_r <= ifc_cnt_r - 32'h1;
          end
        end
        default: state_r <= gpib_ops_pkg::MS_RUN;
      endcase
    end
  end

  // ==========================================================
  // Entry intake and length limit
  // Overlong sequences are swallowed so the host never stalls on them
  assign seq_over = seq_cnt_r >= `SEQ_MAX;
  assign seq_ready = run && (seq_over || fifo_in_ready);
  assign seq_take = send_sequence_op && seq_ready;
  assign fifo_in_valid = send_sequence_op && run && !seq_over;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seq_cnt_r <= 9'h000;
    end else if (warm_reset_op) begin
      seq_cnt_r <= 9'h000;
    end else if (seq_take) begin
      seq_cnt_r <= seq_last ? 9'h000 : (seq_over ? seq_cnt_r : seq_cnt_r + 9'h001);
    end
  end

  seq_fifo #(
    .WIDTH(12),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({seq_kind, seq_arg}),
    .out_valid(fifo_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_data)
  );

  // ==========================================================
  // Entry decode
  always_comb begin
    head_kind = fifo_data[11:8];
    head_arg = fifo_data[7:0];
    tx_byte = head_arg;
    tx_eoi = 1'b0;
    head_cmd = 1'b1;
    head_bad = 1'b0;
    case (head_kind)
      `K_CMD: tx_byte = head_arg;
      `K_UNT: tx_byte = `UNT_BYTE;
      `K_UNL: tx_byte = `UNL_BYTE;
      `K_MTA: tx_byte = `TAG_BASE | {3'h0, my_addr};
      `K_MLA: tx_byte = `LAG_BASE | {3'h0, my_addr};
      `K_TALK: begin
        tx_byte = `TAG_BASE | {3'h0, head_arg[4:0]};
        head_bad = head_arg > `ADDR_MAX;
      end
      `K_LISTEN: begin
        tx_byte = `LAG_BASE | {3'h0, head_arg[4:0]};
        head_bad = head_arg > `ADDR_MAX;
      end
      `K_DATA: head_cmd = 1'b0;
      `K_DATA_EOI: begin
        head_cmd = 1'b0;
        tx_eoi = 1'b1;
      end
      default: head_bad = 1'b1;
    endcase
  end

  // Command bytes need the controller role; data may go from any role
  assign not_cic_hit = head_cmd && !controller_active && !head_bad;
  assign head_drop = head_bad || not_cic_hit;
  assign tx_valid = run && fifo_valid && !head_drop;
  assign fifo_out_ready = run && (head_drop || tx_ready);
  assign pop_ok = fifo_valid && fifo_out_ready;
  assign send_go = tx_valid && tx_ready;
  assign busy_out = fifo_valid || !tx_ready;

  // ==========================================================
  // Attention line
  assign resume_ok = release_attention_op && controller_active;
  assign resume_bad = release_attention_op && !controller_active;
  // ATN follows an entry as the handshake leaves idle, where settle time covers it; warm reset clears it in any state, resume unless an entry starts that cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      atn_out <= 1'b0;
    end else if (warm_reset_op) begin
      atn_out <= 1'b0;
    end else if (send_go) begin
      atn_out <= head_cmd;
    end else if (resume_ok) begin
      atn_out <= 1'b0;
    end
  end

  // ==========================================================
  // Error flags, a new error beats the clear
  // errors
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_not_cic_out <= 1'b0;
      err_arg_out <= 1'b0;
      err_len_out <= 1'b0;
    end else begin
      err_not_cic_out <= (err_not_cic_out && !warm_reset_op) || resume_bad
        || (pop_ok && not_cic_hit);
      err_arg_out <= (err_arg_out && !warm_reset_op) || (pop_ok && head_bad);
      err_len_out <= (err_len_out && !warm_reset_op) || (seq_take && seq_over);
    end
  end

  // ==========================================================
  // Byte handshake
  bus_source_hs #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_hs (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .abort(flush),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_byte(tx_byte),
    .tx_eoi(tx_eoi),
    .dio_out(dio_out),
    .dio_oe(dio_oe),
    .dav_out(dav_out),
    .eoi_out(eoi_out),
    .nrfd_in(nrfd_in),
    .ndac_in(ndac_in)
  );

  // ==========================================================
  // Checks
  logic [31:0] ifc_hi_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) ifc_hi_r <= 32'h0;
    else ifc_hi_r <= ifc_out ? ifc_hi_r + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_peri_load;
    set_poll_response_op && !controller_active;
  endsequence
  sequence s_go(logic [3:0] k);
    send_go && head_kind == k && !warm_reset_op;
  endsequence

  property p_poll_load;
    s_peri_load |=> poll_resp_out == $past(poll_byte_in);
  endproperty
  a_poll_load: assert property (p_poll_load) else $error("Poll byte not loaded");
  property p_poll_role;
    set_poll_response_op && controller_active && !poll_served |=> $stable(poll_resp_out);
  endproperty
  a_poll_role: assert property (p_poll_role) else $error("Poll byte loaded as controller");
  property p_srq_raise;
    s_peri_load ##1 !controller_active |-> srq_out == $past(poll_byte_in[`RSV_BIT]);
  endproperty
  a_srq_raise: assert property (p_srq_raise) else $error("SRQ not following rsv");
  property p_poll_clear;
    poll_served && !set_poll_response_op |=> !poll_resp_out[`RSV_BIT] && !srq_out;
  endproperty
  a_poll_clear: assert property (p_poll_clear) else $error("Rsv not cleared by poll");
  property p_warm_defaults;
    warm_reset_op |=> !running_out && !trigger_armed_out && buf_increment_out
      && dma_single_out && !atn_out && flush ##1 !dav_out && !dio_oe;
  endproperty
  a_warm_defaults: assert property (p_warm_defaults) else $error("Defaults not restored");
  property p_warm_errors;
    warm_reset_op && !resume_bad && !seq_take && !pop_ok |=> !err_len_out && !err_arg_out;
  endproperty
  a_warm_errors: assert property (p_warm_errors) else $error("Errors not cleared");
  property p_ifc_start;
    warm_reset_op ##1 (flush && system_controller) |=> ifc_out [*8];
  endproperty
  a_ifc_start: assert property (p_ifc_start) else $error("IFC not asserted");
  property p_ifc_len;
    $fell(ifc_out) && !$past(warm_reset_op) |-> $past(ifc_hi_r) >= 32'(IFC_CYCLES - 1);
  endproperty
  a_ifc_len: assert property (p_ifc_len) else $error("IFC too short");
  property p_resume;
    resume_ok && !send_go && !warm_reset_op |=> !atn_out;
  endproperty
  a_resume: assert property (p_resume) else $error("ATN not released");
  property p_resume_refuse;
    resume_bad |=> err_not_cic_out;
  endproperty
  a_resume_refuse: assert property (p_resume_refuse) else $error("Resume not refused");
  property p_len;
    seq_take && seq_over |-> !fifo_in_valid ##1 err_len_out;
  endproperty
  a_len: assert property (p_len) else $error("Overlong sequence accepted");
  property p_cmd_no_eoi;
    s_go(`K_CMD) |=> atn_out && !eoi_out && dio_out == $past(head_arg);
  endproperty
  a_cmd_no_eoi: assert property (p_cmd_no_eoi) else $error("Raw command wrong");
  property p_unt;
    s_go(`K_UNT) |=> atn_out && dio_out == `UNT_BYTE;
  endproperty
  a_unt: assert property (p_unt) else $error("Untalk byte wrong");
  property p_unl;
    s_go(`K_UNL) |=> atn_out && dio_out == `UNL_BYTE;
  endproperty
  a_unl: assert property (p_unl) else $error("Unlisten byte wrong");
  property p_mta;
    s_go(`K_MTA) |=> atn_out && dio_out == (`TAG_BASE | {3'h0, $past(my_addr)});
  endproperty
  a_mta: assert property (p_mta) else $error("Own talk byte wrong");
  property p_addr_range;
    pop_ok && (head_kind == `K_TALK || head_kind == `K_LISTEN) && head_arg > `ADDR_MAX
      |-> !send_go ##1 err_arg_out;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("Bad address sent");
  property p_data;
    s_go(`K_DATA) |=> !atn_out && !eoi_out && dio_out == $past(head_arg);
  endproperty
  a_data: assert property (p_data) else $error("Data sent with ATN");
  property p_data_eoi;
    s_go(`K_DATA_EOI) |=> !atn_out && eoi_out;
  endproperty
  a_data_eoi: assert property (p_data_eoi) else $error("EOI missing on last byte");
endmodule : gpib_poll_reset_send_ops
`default_nettype wire

//--- bench/gpib_listener_model.sv
// Listener model that answers the three-wire byte handshake
`timescale 1ns/1ps
`default_nettype none
module gpib_listener_model (
  // Clock, reset and pacing
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic slow,
  // Source lines
  input wire logic dav_out,
  input wire logic [7:0] dio_out,
  input wire logic dio_oe,
  input wire logic atn_out,
  input wire logic eoi_out,
  // Answers and captured byte
  output logic nrfd_in,
  output logic ndac_in,
  output logic got_stb,
  output logic [9:0] got
);
  // ====
  // Handshake
  logic [1:0] wait_r;
  logic held_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nrfd_in <= 1'b1;
      ndac_in <= 1'b1;
      held_r <= 1'b0;
      wait_r <= 2'h0;
      got_stb <= 1'b0;
      got <= 10'h000;
    end else begin
      got_stb <= 1'b0;
      if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (!held_r && dav_out && !nrfd_in) begin
        nrfd_in <= 1'b1;
        ndac_in <= 1'b0;
        held_r <= 1'b1;
        got_stb <= 1'b1;
        // An undriven bus shows as inverted data, never as a lucky match
        got <= {atn_out, eoi_out, dio_oe ? dio_out : ~dio_out};
        wait_r <= slow ? 2'h3 : 2'h0;
      end else if (held_r && !dav_out) begin
        ndac_in <= 1'b1;
        held_r <= 1'b0;
        wait_r <= slow ? 2'h3 : 2'h0;
      end else if (!held_r) begin
        nrfd_in <= 1'b0;
      end
    end
  end
endmodule : gpib_listener_model
`default_nettype wire

//--- bench/test_gpib_poll_reset_send_ops.sv
// Self-checking bench for the poll, reset, resume and send block
`timescale 1ns/1ps
`default_nettype none
`include "gpib_ops_defs.svh"
module test_gpib_poll_reset_send_ops;
  // ====
  // Signals
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic controller_active = 1'b0;
  logic system_controller = 1'b0;
  logic slow = 1'b0;
  logic [5:0] op = 6'h00;
  logic [3:0] mode_in = 4'h0;
  logic [7:0] poll_byte_in = 8'h00;
  logic [7:0] config_in = 8'h00;
  logic send_sequence_op = 1'b0;
  logic [3:0] seq_kind = 4'h0;
  logic [7:0] seq_arg = 8'h00;
  logic seq_last = 1'b0;
  logic seq_ready, busy_out, err_not_cic_out, err_arg_out, err_len_out, got_stb;
  logic running_out, trigger_armed_out, buf_increment_out, dma_single_out;
  logic atn_out, ifc_out, srq_out, dio_oe, dav_out, eoi_out, nrfd_in, ndac_in;
  logic [7:0] poll_resp_out, config_out, dio_out;
  logic [9:0] got;
  logic [9:0] rxq[$];
  logic [3:0] tk[10] = '{`K_CMD, `K_UNT, `K_UNL, `K_MTA, `K_MLA, `K_TALK, `K_LISTEN,
    `K_LISTEN, `K_DATA, `K_DATA_EOI};
  logic [7:0] ta[10] = '{8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1E, 8'h05, 8'h00, 8'h12, 8'h34};
  logic [9:0] tx[10] = '{10'h241, 10'h25F, 10'h23F, 10'h24B, 10'h22B, 10'h25E, 10'h225,
    10'h220, 10'h012, 10'h134};
  int error_cnt = 0;
  int checks = 0;
  int n;
  int stalled = 0;
  int ifc_cnt = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (got_stb === 1'b1) rxq.push_back(got);
  // ====
  // Design and far side
  gpib_poll_reset_send_ops #(.IFC_CYCLES(20), .SETTLE_CYCLES(2), .FIFO_DEPTH(8)) u_dut (
    .clk_sys, .reset_n, .controller_active, .system_controller, .my_addr(5'h0B),
    .set_poll_response_op(op[0]), .poll_byte_in, .poll_served(op[1]), .poll_resp_out,
    .warm_reset_op(op[2]), .mode_we(op[4]), .mode_in, .config_we(op[5]), .config_in,
    .running_out, .trigger_armed_out, .buf_increment_out, .dma_single_out, .config_out,
    .release_attention_op(op[3]), .send_sequence_op, .seq_ready, .seq_kind, .seq_arg,
    .seq_last, .busy_out, .err_not_cic_out, .err_arg_out, .err_len_out, .atn_out, .ifc_out,
    .srq_out, .dio_out, .dio_oe, .dav_out, .eoi_out, .nrfd_in, .ndac_in);
  gpib_listener_model u_far (.clk_sys, .reset_n, .slow, .dav_out, .dio_out, .dio_oe, .atn_out,
    .eoi_out, .nrfd_in, .ndac_in, .got_stb, .got);
  // ====
  // Tasks
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic give_up;
    error_cnt++;
    $display("unexpected at %0t: wait limit reached", $time);
    final_report();
  endtask : give_up
  task automatic pulse(input int b);
    @(posedge clk_sys);
    op[b] <= 1'b1;
    @(posedge clk_sys);
    op <= 6'h00;
    @(negedge clk_sys);
  endtask : pulse
  // Leaves the entry valid; the caller ends a burst with put_end
  task automatic put(input logic [3:0] k, input logic [7:0] a, input logic l);
    // Outside a burst, line up with a rising edge so the entry is taken only once
    if (send_sequence_op !== 1'b1) @(posedge clk_sys);
    send_sequence_op <= 1'b1;
    seq_kind <= k;
    seq_arg <= a;
    seq_last <= l;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (seq_ready !== 1'b1 && n < 4000);
    if (n >= 4000) give_up();
    if (n > 1) stalled = 1;
    @(posedge clk_sys);
  endtask : put
  task automatic put_end;
    send_sequence_op <= 1'b0;
    seq_last <= 1'b0;
  endtask : put_end
  task automatic expect_byte(input logic [9:0] exp);
    n = 0;
    while (rxq.size() == 0 && n < 4000) begin @(negedge clk_sys); n++; end
    if (n >= 4000) give_up();
    chk({2'b00, rxq.pop_front()}, {2'b00, exp});
  endtask : expect_byte
  task automatic drain;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (busy_out !== 1'b0 && n < 8000);
    if (n >= 8000) give_up();
  endtask : drain
  // ====
  // Sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk({running_out, trigger_armed_out, buf_increment_out, dma_single_out, 8'h00}, 12'h300);
    chk({1'b0, err_not_cic_out, err_arg_out, err_len_out, poll_resp_out}, 12'h000);
    @(posedge clk_sys);
    poll_byte_in <= 8'h40;
    pulse(0);
    chk({3'h0, srq_out, poll_resp_out}, 12'h140);
    pulse(1);
    chk({3'h0, srq_out, poll_resp_out}, 12'h000);
    @(posedge clk_sys);
    poll_byte_in <= 8'h85;
    pulse(0);
    chk({3'h0, srq_out, poll_resp_out}, 12'h085);
    pulse(3);
    chk({1'b0, err_not_cic_out, 2'b00, 7'h00, atn_out}, 12'h400);
    put(`K_DATA, 8'h55, 1'b1);
    put_end();
    expect_byte(10'h055);
    @(posedge clk_sys);
    controller_active <= 1'b1;
    poll_byte_in <= 8'hFF;
    pulse(0);
    chk({4'h0, poll_resp_out}, 12'h085);
    @(posedge clk_sys);
    slow <= 1'b1;
    for (int i = 0; i < 10; i++) put(tk[i], ta[i], i == 9);
    put_end();
    for (int i = 0; i < 10; i++) expect_byte(tx[i]);
    drain();
    chk(12'(stalled), 12'h001);
    @(posedge clk_sys);
    slow <= 1'b0;
    put(`K_UNT, 8'h00, 1'b1);
    put_end();
    drain();
    chk({11'h000, atn_out}, 12'h001);
    pulse(3);
    chk({11'h000, atn_out}, 12'h000);
    rxq.delete();
    put(`K_TALK, 8'h1F, 1'b1);
    put(`K_LISTEN, 8'h1E, 1'b1);
    put_end();
    expect_byte(10'h23E);
    chk({9'h000, err_not_cic_out, err_arg_out, err_len_out}, 12'h006);
    for (int i = 0; i < 255; i++) put(`K_DATA, i[7:0], 1'b0);
    put_end();
    @(negedge clk_sys);
    chk({11'h000, err_len_out}, 12'h000);
    put(`K_DATA, 8'hAA, 1'b1);
    put_end();
    drain();
    chk({11'h000, err_len_out}, 12'h001);
    chk(12'(rxq.size()), 12'h0FF);
    @(posedge clk_sys);
    mode_in <= 4'hF;
    config_in <= 8'hA5;
    pulse(4);
    pulse(5);
    chk({running_out, trigger_armed_out, buf_increment_out, dma_single_out, config_out}, 12'hCA5);
    @(posedge clk_sys);
    system_controller <= 1'b1;
    pulse(2);
    chk({running_out, trigger_armed_out, buf_increment_out, dma_single_out, config_out}, 12'h300);
    chk({9'h000, err_not_cic_out, err_arg_out, err_len_out}, 12'h000);
    repeat (60) begin @(negedge clk_sys); if (ifc_out === 1'b1) ifc_cnt++; end
    chk(12'(ifc_cnt), 12'h014);
    chk({11'h000, seq_ready}, 12'h001);
    final_report();
  end
endmodule : test_gpib_poll_reset_send_ops
`default_nettype wire
